// >>> pkg/lps_cfg.svh
// Purpose: constants of the light and proximity sequencer
// Assumes: 25 MHz pclk
// Notes:   times are given in their own unit, cycle counts derive from them
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH

`define LPS_CLK_KHZ        25000
`define LPS_ALS_CONV_MS    100
`define LPS_PROX_CONV_US   540
`define LPS_LED_PULSE_US   100
`define LPS_SLEEP_MAX_MS   800

`define LPS_TMR_W          25
`define LPS_ALS_W          12
`define LPS_PROX_W         8

// register byte offsets
`define LPS_REG_CONFIG     8'h00
`define LPS_REG_ALS_LOW    8'h04
`define LPS_REG_ALS_HIGH   8'h08
`define LPS_REG_PROX_THR   8'h0c
`define LPS_REG_STATUS     8'h10
`define LPS_REG_MASK       8'h14
`define LPS_REG_ALS_DATA   8'h18
`define LPS_REG_PROX_DATA  8'h1c
`define LPS_REG_STRAP      8'h20

// config fields
`define LPS_CFG_RUN        0
`define LPS_CFG_ALS_EN     1
`define LPS_CFG_PROX_EN    2
`define LPS_CFG_RANGE      3
`define LPS_CFG_AMP        4
`define LPS_CFG_SLEEP_LO   5
`define LPS_CFG_SLEEP_HI   7
`define LPS_CFG_AND        8
`define LPS_CFG_APERS_LO   9
`define LPS_CFG_APERS_HI   10
`define LPS_CFG_PPERS_LO   11
`define LPS_CFG_PPERS_HI   12
`define LPS_CFG_W          13
`define LPS_CFG_RESET      13'h0000

// status / mask fields
`define LPS_ST_ALS_INT     0
`define LPS_ST_PROX_INT    1
`define LPS_ST_ALS_DONE    2
`define LPS_ST_PROX_DONE   3
`define LPS_ST_W           4

`define LPS_ALS_LOW_RESET  12'h000
`define LPS_ALS_HIGH_RESET 12'hfff
`define LPS_PROX_THR_RESET 8'hff

`endif

// >>> pkg/lps_pkg.sv
// Purpose: shared types of the light and proximity sequencer
// Assumes: nothing
// Notes:   one-hot proximity sequence states
package lps_pkg;

	typedef enum logic [2:0]
	{
		LPS_PX_SLEEP = 3'b001,
		LPS_PX_LED   = 3'b010,
		LPS_PX_CONV  = 3'b100
	} lps_px_state_t;

	typedef logic [1:0] lps_pers_t;

endpackage

// >>> rtl/lps_persist.sv
// Purpose: consecutive-trigger filter for one interrupt source
// Assumes: sample is a one-cycle strobe per result
// Notes:   fire is a one-cycle pulse on the qualifying result
`timescale 1ns/100ps
`include "lps_cfg.svh"

module lps_persist
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             sample,
	input  wire logic             trigger,
	input  wire lps_pkg::lps_pers_t sel,
	input  wire logic             restart,
	output logic                  fire
);
	import lps_pkg::*;

	logic [4:0] count;
	logic [4:0] need;
	logic [4:0] next_count;

	always_comb
	begin
		unique case (sel)
			2'h0: need = 5'h01;
			2'h1: need = 5'h04;
			2'h2: need = 5'h08;
			2'h3: need = 5'h10;
		endcase
	end

	always_comb
	begin
		next_count = count;
		if (sample && !trigger)
			next_count = 5'h00;
		else if (sample && count < need)
			next_count = count + 5'h01;
	end

	// a restart from the host clear wins over a result in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= 5'h00;
		else if (restart)
			count <= 5'h00;
		else
			count <= next_count;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fire <= 1'b0;
		else
			fire <= !restart && sample && trigger && (next_count == need) && (count < need);
	end

endmodule

// >>> rtl/lps_top.sv
// Purpose: sequencing and interrupt logic of an ambient light and proximity sensor
// Assumes: converter results are produced by logic on pclk; APB slave, zero wait on access
// Notes:   long timer counts are parameters so a simulation can shorten them
// Functional notes
// - ambient-light and proximity conversions run on separate timers, neither waits.
// - each ambient-light conversion takes 100 ms.
// - each proximity conversion takes 540 us.
// - during a proximity conversion the LED sink is switched on and the result is taken.
// - the LED pulse lasts 100 us and its amplitude is host-selectable between 110 and 220 mA.
// - between proximity pulses the block sleeps for a programmable time of at most 800 ms.
// - an ambient-light result outside the low/high window is a trigger.
// - a proximity result above the threshold is a trigger.
// - a flag needs 1, 4, 8 or 16 consecutive triggers; a non-trigger restarts the count.
// - optionally the interrupt needs both channels to trigger together, up to 16 times in a row.
// - an interrupt event sets readable status bits and, where its mask bit is set, drives the interrupt pin.
// - the interrupt pin is open drain, pulled low when active and released otherwise.
// - the ambient-light range is host-selectable, 125 lux or 2000 lux.
`timescale 1ns/100ps
`include "lps_cfg.svh"

module lps_top
#(
	parameter int ALS_CONV_CYC  = `LPS_ALS_CONV_MS * `LPS_CLK_KHZ,
	parameter int PROX_CONV_CYC = `LPS_PROX_CONV_US * `LPS_CLK_KHZ / 1000,
	parameter int SLEEP_MAX_CYC = `LPS_SLEEP_MAX_MS * `LPS_CLK_KHZ
)
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [`LPS_ALS_W-1:0]  ambient_light_channel_code,
	input  wire logic [`LPS_PROX_W-1:0] prox_code,
	output logic                        ambient_light_channel_range,
	output logic                        als_converting,
	output logic                        prox_converting,
	output logic                        led_sink_pin_on,
	output logic                        led_sink_pin_high_amp,
	input  wire logic                   address_select_pin,
	output logic                        i2c_addr_bit,
	output logic                        int_pin_o,
	output logic                        int_pin_oe,
	output logic                        irq
);
	import lps_pkg::*;

	localparam int LED_CYC = `LPS_LED_PULSE_US * `LPS_CLK_KHZ / 1000;

	logic [`LPS_CFG_W-1:0]  cfg;
	logic [`LPS_ALS_W-1:0]  als_low;
	logic [`LPS_ALS_W-1:0]  als_high;
	logic [`LPS_PROX_W-1:0] prox_thr;
	logic [`LPS_ST_W-1:0]   status;
	logic [`LPS_ST_W-1:0]   mask;
	logic [`LPS_ALS_W-1:0]  als_data;
	logic [`LPS_PROX_W-1:0] prox_data;
	logic                   strap_s1;
	logic                   strap_s2;
	logic                   strap_taken;
	logic                   strap;

	logic                   run;
	logic                   wr_en;
	logic                   setup;
	logic [7:0]             addr;
	logic [`LPS_ST_W-1:0]   clr;
	logic [`LPS_ST_W-1:0]   set;

	logic [`LPS_TMR_W-1:0]  als_tmr;
	logic                   als_sample;
	logic [`LPS_TMR_W-1:0]  px_tmr;
	logic [`LPS_TMR_W-1:0]  sleep_cyc;
	lps_px_state_t          px_state;
	logic                   prox_sample;

	logic                   als_trig;
	logic                   prox_trig;
	logic                   als_trig_last;
	logic                   prox_trig_last;
	logic [2:0]             p_sample;
	logic [2:0]             p_trig;
	logic [2:0]             p_restart;
	lps_pers_t              p_sel [3];
	logic [2:0]             p_fire;

	assign run   = cfg[`LPS_CFG_RUN];
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite;
	assign addr  = paddr[7:0];

	// apb: read data and error latched in setup, every access ends after one access cycle
	assign pready = psel && penable;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
			unique case (addr)
				`LPS_REG_CONFIG:    prdata[`LPS_CFG_W-1:0] <= cfg;
				`LPS_REG_ALS_LOW:   prdata[`LPS_ALS_W-1:0] <= als_low;
				`LPS_REG_ALS_HIGH:  prdata[`LPS_ALS_W-1:0] <= als_high;
				`LPS_REG_PROX_THR:  prdata[`LPS_PROX_W-1:0] <= prox_thr;
				`LPS_REG_STATUS:    prdata[`LPS_ST_W-1:0] <= status;
				`LPS_REG_MASK:      prdata[`LPS_ST_W-1:0] <= mask;
				`LPS_REG_ALS_DATA:  prdata[`LPS_ALS_W-1:0] <= als_data;
				`LPS_REG_PROX_DATA: prdata[`LPS_PROX_W-1:0] <= prox_data;
				`LPS_REG_STRAP:     prdata[0] <= strap;
				default:            pslverr <= (paddr[31:8] != 24'h0) || 1'b1;
			endcase
			if (paddr[31:8] != 24'h0 || paddr[1:0] != 2'h0)
				pslverr <= 1'b1;
		end
	end

	// writable registers stay alive while powered down
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg      <= `LPS_CFG_RESET;
			als_low  <= `LPS_ALS_LOW_RESET;
			als_high <= `LPS_ALS_HIGH_RESET;
			prox_thr <= `LPS_PROX_THR_RESET;
			mask     <= '0;
		end
		else if (wr_en && !pslverr)
		begin
			unique case (addr)
				`LPS_REG_CONFIG:   cfg      <= pwdata[`LPS_CFG_W-1:0];
				`LPS_REG_ALS_LOW:  als_low  <= pwdata[`LPS_ALS_W-1:0];
				`LPS_REG_ALS_HIGH: als_high <= pwdata[`LPS_ALS_W-1:0];
				`LPS_REG_PROX_THR: prox_thr <= pwdata[`LPS_PROX_W-1:0];
				`LPS_REG_MASK:     mask     <= pwdata[`LPS_ST_W-1:0];
				default:           ;
			endcase
		end
	end

	// the strap synchroniser has no reset: it fills while reset is held, so the
	// one-time capture at the first edge after release sees the pin and not a cleared flop
	always_ff @(posedge pclk)
	begin
		strap_s1 <= address_select_pin;
		strap_s2 <= strap_s1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap_taken <= 1'b0;
			strap       <= 1'b0;
		end
		else if (!strap_taken)
		begin
			strap_taken <= 1'b1;
			strap       <= strap_s2;
		end
	end

	assign i2c_addr_bit = strap;

	// ambient-light channel: free running conversion timer of its own
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			als_tmr <= '0;
		else if (!run || !cfg[`LPS_CFG_ALS_EN])
			als_tmr <= '0;
		else if (als_tmr == `LPS_TMR_W'(ALS_CONV_CYC - 1))
			als_tmr <= '0;
		else
			als_tmr <= als_tmr + `LPS_TMR_W'(1);
	end

	assign als_sample = run && cfg[`LPS_CFG_ALS_EN] && (als_tmr == `LPS_TMR_W'(ALS_CONV_CYC - 1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			als_converting <= 1'b0;
		else
			als_converting <= run && cfg[`LPS_CFG_ALS_EN];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ambient_light_channel_range <= 1'b0;
		else
			ambient_light_channel_range <= cfg[`LPS_CFG_RANGE];
	end

	// sleep selection halves the longest period per step, so 800 ms is the ceiling
	assign sleep_cyc = `LPS_TMR_W'(SLEEP_MAX_CYC) >> cfg[`LPS_CFG_SLEEP_HI:`LPS_CFG_SLEEP_LO];

	// proximity channel: sleep, led pulse inside the conversion, then sample
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			px_state <= LPS_PX_SLEEP;
			px_tmr   <= '0;
		end
		else if (!run || !cfg[`LPS_CFG_PROX_EN])
		begin
			px_state <= LPS_PX_SLEEP;
			px_tmr   <= '0;
		end
		else
		begin
			unique case (px_state)
				LPS_PX_SLEEP:
					if (px_tmr >= sleep_cyc - `LPS_TMR_W'(1))
					begin
						px_state <= LPS_PX_LED;
						px_tmr   <= '0;
					end
					else
						px_tmr <= px_tmr + `LPS_TMR_W'(1);
				LPS_PX_LED:
				begin
					px_tmr <= px_tmr + `LPS_TMR_W'(1);
					if (px_tmr == `LPS_TMR_W'(LED_CYC - 1))
						px_state <= LPS_PX_CONV;
				end
				LPS_PX_CONV:
					if (px_tmr == `LPS_TMR_W'(PROX_CONV_CYC - 1))
					begin
						px_state <= LPS_PX_SLEEP;
						px_tmr   <= '0;
					end
					else
						px_tmr <= px_tmr + `LPS_TMR_W'(1);
				default:
				begin
					px_state <= LPS_PX_SLEEP;
					px_tmr   <= '0;
				end
			endcase
		end
	end

	assign prox_sample = run && cfg[`LPS_CFG_PROX_EN] && (px_state == LPS_PX_CONV)
		&& (px_tmr == `LPS_TMR_W'(PROX_CONV_CYC - 1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			led_sink_pin_on       <= 1'b0;
			led_sink_pin_high_amp <= 1'b0;
			prox_converting       <= 1'b0;
		end
		else
		begin
			led_sink_pin_on       <= run && cfg[`LPS_CFG_PROX_EN] && (px_state == LPS_PX_LED);
			led_sink_pin_high_amp <= cfg[`LPS_CFG_AMP];
			prox_converting       <= run && cfg[`LPS_CFG_PROX_EN] && (px_state != LPS_PX_SLEEP);
		end
	end

	// results are captured at the end of each conversion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			als_data <= '0;
		else if (als_sample)
			als_data <= ambient_light_channel_code;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prox_data <= '0;
		else if (prox_sample)
			prox_data <= prox_code;
	end

	assign als_trig  = (ambient_light_channel_code < als_low)
		|| (ambient_light_channel_code > als_high);
	assign prox_trig = prox_code > prox_thr;

	// last result of each channel, for the joint mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			als_trig_last  <= 1'b0;
			prox_trig_last <= 1'b0;
		end
		else
		begin
			if (als_sample)
				als_trig_last <= als_trig;
			if (prox_sample)
				prox_trig_last <= prox_trig;
		end
	end

	assign clr = (wr_en && !pslverr && addr == `LPS_REG_STATUS) ? pwdata[`LPS_ST_W-1:0] : '0;

	// filters 0/1 per channel, filter 2 counts joint results
	assign p_sample[0]  = als_sample && !cfg[`LPS_CFG_AND];
	assign p_sample[1]  = prox_sample && !cfg[`LPS_CFG_AND];
	assign p_sample[2]  = (als_sample || prox_sample) && cfg[`LPS_CFG_AND];
	assign p_trig[0]    = als_trig;
	assign p_trig[1]    = prox_trig;
	assign p_trig[2]    = (als_sample ? als_trig : als_trig_last)
		&& (prox_sample ? prox_trig : prox_trig_last);
	assign p_sel[0]     = cfg[`LPS_CFG_APERS_HI:`LPS_CFG_APERS_LO];
	assign p_sel[1]     = cfg[`LPS_CFG_PPERS_HI:`LPS_CFG_PPERS_LO];
	assign p_sel[2]     = cfg[`LPS_CFG_PPERS_HI:`LPS_CFG_PPERS_LO];
	assign p_restart[0] = clr[`LPS_ST_ALS_INT] || !run;
	assign p_restart[1] = clr[`LPS_ST_PROX_INT] || !run;
	assign p_restart[2] = (clr[`LPS_ST_ALS_INT] || clr[`LPS_ST_PROX_INT]) || !run;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_pers
			lps_persist u_pers
			(
				.pclk    (pclk),
				.presetn (presetn),
				.sample  (p_sample[gi]),
				.trigger (p_trig[gi]),
				.sel     (p_sel[gi]),
				.restart (p_restart[gi]),
				.fire    (p_fire[gi])
			);
		end
	endgenerate

	always_comb
	begin
		set = '0;
		set[`LPS_ST_ALS_INT]   = p_fire[0] || p_fire[2];
		set[`LPS_ST_PROX_INT]  = p_fire[1] || p_fire[2];
		set[`LPS_ST_ALS_DONE]  = als_sample;
		set[`LPS_ST_PROX_DONE] = prox_sample;
	end

	// sticky status, write one to clear; a set in the same cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status <= '0;
		else
			status <= (status & ~clr) | set;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(status & mask);
	end

	// open drain: only ever drive low
	assign int_pin_o  = 1'b0;
	assign int_pin_oe = irq;

endmodule

// >>> testbench/light_proximity_interrupt_sequencer_test.sv
// Purpose: self-checking bench of lps_top
// Assumes: shortened conversion counts, strap tied high
// Notes:   expectations come from integer window and persistence models
`timescale 1ns/100ps
`include "lps_cfg.svh"

module light_proximity_interrupt_sequencer_test;
	localparam int ALS_C = 200;
	localparam int PROX_C = 3000;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, rng, als_cv, prox_cv, led_on, led_hi, abit, int_o, int_oe;
	logic        irq, trig;
	logic [11:0] als_val = 12'h0, als_code;
	logic [7:0]  prox_val = 8'h0, prox_code;
	wire         int_line;
	int          errors = 0, n_compared = 0, seed = 96, cnt, n;
	logic [31:0] ra [7] = '{`LPS_REG_CONFIG, `LPS_REG_ALS_LOW, `LPS_REG_ALS_HIGH,
		`LPS_REG_PROX_THR, `LPS_REG_STATUS, `LPS_REG_MASK, `LPS_REG_STRAP};
	logic [31:0] rv [7] = '{0, 0, 32'hfff, 32'hff, 0, 0, 1};

	always #20 pclk = ~pclk;

	lps_top #(.ALS_CONV_CYC(ALS_C), .PROX_CONV_CYC(PROX_C), .SLEEP_MAX_CYC(400)) dut_u
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.ambient_light_channel_code(als_code), .prox_code, .ambient_light_channel_range(rng),
		.als_converting(als_cv), .prox_converting(prox_cv), .led_sink_pin_on(led_on),
		.led_sink_pin_high_amp(led_hi), .i2c_addr_bit(abit),
		.address_select_pin(1'b1),
		.int_pin_o(int_o), .int_pin_oe(int_oe), .irq
	);

	lps_light_model model_u
	(
		.als_val, .prox_val, .als_converting(als_cv), .prox_converting(prox_cv),
		.int_pin_o(int_o), .int_pin_oe(int_oe), .als_code, .prox_code, .int_line
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// called right after a rising edge; one idle edge at the end keeps drivers single
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wait_bit(input int b, input int lim);
		int k;
		k = 0;
		do
		begin
			apb(1'b0, `LPS_REG_STATUS, 0);
			k++;
		end
		while (rd[b] !== 1'b1 && k < lim);
		chk(rd[b], 1);
	endtask

	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#1600000;
		errors++;
		$display("MISMATCH t=%0t watchdog", $time);
		tally_and_finish();
	end

	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b0, ra[i], 0);
			chk(rd, rv[i]);
		end
		apb(1'b0, 32'h24, 0);
		chk({rd[30:0], err}, 1);
		apb(1'b0, 32'h100, 0);
		chk(err, 1);
		chk(abit, 1);
		$display("test 1 done");
		apb(1'b1, `LPS_REG_ALS_LOW, 32'h100);
		apb(1'b1, `LPS_REG_ALS_HIGH, 32'hc00);
		apb(1'b1, `LPS_REG_MASK, 32'h3);
		apb(1'b1, `LPS_REG_CONFIG, 32'h3);
		for (int i = 0; i < 6; i++)
		begin
			als_val <= (i == 0) ? 12'hc01 : (i == 1) ? 12'h100 : 12'($random(seed));
			wait_bit(`LPS_ST_ALS_DONE, 300);
			repeat (4) @(posedge pclk);
			trig = als_val < 12'h100 || als_val > 12'hc00;
			apb(1'b0, `LPS_REG_ALS_DATA, 0);
			chk(rd, {20'h0, als_val});
			apb(1'b0, `LPS_REG_STATUS, 0);
			chk(rd[0], trig);
			chk(irq, trig);
			chk(int_line, !trig);
			apb(1'b1, `LPS_REG_STATUS, 32'hf);
			repeat (3) @(posedge pclk);
			chk(irq, 0);
		end
		$display("test 2 done");
		apb(1'b1, `LPS_REG_MASK, 32'h1);
		for (int s = 0; s < 4; s++)
		begin
			n = (s == 0) ? 1 : 2 << s;
			apb(1'b1, `LPS_REG_CONFIG, 0);
			apb(1'b1, `LPS_REG_STATUS, 32'hf);
			als_val <= 12'hfff;
			apb(1'b1, `LPS_REG_CONFIG, (32'(s) << 9) | 32'h3);
			cnt = 0;
			while (irq !== 1'b1 && cnt < 4000)
			begin
				@(posedge pclk);
				cnt++;
			end
			chk(cnt >= n * ALS_C - 4 && cnt <= n * ALS_C + 6, 1);
		end
		$display("test 3 done");
		apb(1'b1, `LPS_REG_CONFIG, 0);
		apb(1'b1, `LPS_REG_STATUS, 32'hf);
		apb(1'b1, `LPS_REG_PROX_THR, 32'h40);
		prox_val <= {1'b1, 7'($random(seed))};
		apb(1'b1, `LPS_REG_CONFIG, 32'h1f);
		wait_bit(`LPS_ST_PROX_INT, 2000);
		chk(rd[`LPS_ST_ALS_DONE], 1);
		apb(1'b0, `LPS_REG_PROX_DATA, 0);
		chk(rd, {24'h0, prox_val});
		chk({rng, led_hi}, 3);
		$display("test 4 done");
		apb(1'b1, `LPS_REG_CONFIG, 0);
		apb(1'b1, `LPS_REG_STATUS, 32'hf);
		als_val <= 12'h800;
		apb(1'b1, `LPS_REG_CONFIG, 32'h107);
		wait_bit(`LPS_ST_PROX_DONE, 2000);
		chk(rd[1:0], 0);
		als_val <= 12'hfff;
		wait_bit(`LPS_ST_ALS_INT, 300);
		chk(rd[1], 1);
		$display("test 5 done");
		apb(1'b1, `LPS_REG_CONFIG, 32'h16);
		apb(1'b1, `LPS_REG_STATUS, 32'hf);
		repeat (600) @(posedge pclk);
		chk({als_cv, prox_cv, led_on}, 0);
		apb(1'b0, `LPS_REG_STATUS, 0);
		chk(rd, 0);
		apb(1'b0, `LPS_REG_CONFIG, 0);
		chk(rd, 32'h16);
		$display("test 6 done");
		tally_and_finish();
	end
endmodule

bind lps_top lps_top_checker #(.PROX_CONV_CYC(PROX_CONV_CYC)) chk_u
(
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.ambient_light_channel_range, .als_converting, .prox_converting, .led_sink_pin_on,
	.led_sink_pin_high_amp, .int_pin_o, .int_pin_oe, .irq
);

// >>> testbench/lps_light_model.sv
// Purpose: converter front ends and interrupt line of the board
// Assumes: codes are on pclk, the interrupt line has a pull-up
// Notes:   idle converters show the inverted code so a stale sample is caught
`timescale 1ns/100ps
`include "lps_cfg.svh"

module lps_light_model
(
	input  wire logic [`LPS_ALS_W-1:0]  als_val,
	input  wire logic [`LPS_PROX_W-1:0] prox_val,
	input  wire logic                   als_converting,
	input  wire logic                   prox_converting,
	input  wire logic                   int_pin_o,
	input  wire logic                   int_pin_oe,
	output logic [`LPS_ALS_W-1:0]       als_code,
	output logic [`LPS_PROX_W-1:0]      prox_code,
	output wire                         int_line
);
	assign als_code = als_converting ? als_val : ~als_val;
	assign prox_code = prox_converting ? prox_val : ~prox_val;
	assign int_line = int_pin_oe ? int_pin_o : 1'b1;
endmodule

// >>> testbench/lps_top_properties.sv
// Purpose: port-level properties of lps_top
// Assumes: single pclk domain, zero-wait apb slave
// Notes:   led and proximity lengths are counted in helper logic
`timescale 1ns/100ps
`include "lps_cfg.svh"

module lps_top_checker
#(
	parameter int PROX_CONV_CYC = 13500
)
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        ambient_light_channel_range,
	input wire logic        als_converting,
	input wire logic        prox_converting,
	input wire logic        led_sink_pin_on,
	input wire logic        led_sink_pin_high_amp,
	input wire logic        int_pin_o,
	input wire logic        int_pin_oe,
	input wire logic        irq
);
	localparam int LED_CYC = `LPS_LED_PULSE_US * `LPS_CLK_KHZ / 1000;
	logic [15:0] led_len;
	logic [15:0] px_len;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// lengths hold the count of earlier high cycles, so the last high cycle sees length-1
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			led_len <= '0;
		else
			led_len <= led_sink_pin_on ? led_len + 16'h0001 : 16'h0000;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			px_len <= '0;
		else
			px_len <= prox_converting ? px_len + 16'h0001 : 16'h0000;

	sequence s_cfg_wr;
		psel && penable && pwrite && paddr == 32'h0;
	endsequence

	property p_int_drive;
		irq |-> int_pin_oe && !int_pin_o;
	endproperty
	property p_int_release;
		!irq |-> !int_pin_oe;
	endproperty
	property p_led_in_prox;
		led_sink_pin_on |-> prox_converting || $past(prox_converting);
	endproperty
	property p_led_width;
		led_sink_pin_on |-> led_len < LED_CYC;
	endproperty
	property p_led_full;
		$fell(led_sink_pin_on) && prox_converting |-> led_len == LED_CYC;
	endproperty
	property p_prox_len;
		prox_converting |-> px_len < PROX_CONV_CYC;
	endproperty
	property p_ready;
		psel && penable |-> pready;
	endproperty
	property p_unmapped;
		psel && !penable && paddr[31:8] != 24'h0 |=> pslverr;
	endproperty
	property p_cfg_fields;
		s_cfg_wr |=> ##1 ambient_light_channel_range == $past(pwdata[3], 2)
			&& led_sink_pin_high_amp == $past(pwdata[4], 2);
	endproperty
	property p_power_down;
		s_cfg_wr ##0 !pwdata[0] |=> ##2 !als_converting && !prox_converting && !led_sink_pin_on;
	endproperty

	a_int_drive: assert property (p_int_drive) else $error("int pin not driven low");
	a_int_release: assert property (p_int_release) else $error("int pin not released");
	a_led_in_prox: assert property (p_led_in_prox) else $error("led outside prox");
	a_led_width: assert property (p_led_width) else $error("led pulse too long");
	a_led_full: assert property (p_led_full) else $error("led pulse length wrong");
	a_prox_len: assert property (p_prox_len) else $error("prox conversion too long");
	a_ready: assert property (p_ready) else $error("pready missing");
	a_unmapped: assert property (p_unmapped) else $error("no pslverr");
	a_cfg_fields: assert property (p_cfg_fields) else $error("range or amp wrong");
	a_power_down: assert property (p_power_down) else $error("activity powered down");
endmodule
